// ==== sar_adc_sequencer.sv ====
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module sar_adc_sequencer import adc_seq_pkg::*; (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    // wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // system state and converter clock source
    input  wire logic                osc_tick,
    input  wire logic                stop_mode,
    // analog front end
    input  wire logic                cmp_in,
    output logic [RESULT_W-1:0]      dac_code,
    output logic [4:0]               selected_analog_input,
    output logic                     analog_power_on,
    output logic                     done_irq,
    // port pin override
    input  wire logic [NUM_PINS-1:0] pin_in,
    input  wire logic [NUM_PINS-1:0] port_data_latch,
    input  wire logic [NUM_PINS-1:0] port_dir,
    output logic [NUM_PINS-1:0]      analog_channel_pin,
    output logic [NUM_PINS-1:0]      pin_out,
    output logic [NUM_PINS-1:0]      pin_oe,
    output logic [NUM_PINS-1:0]      port_read_value
);

    ctrl_s                 ctrl_reg;        // converter_control_status
    clkcfg_s               clkcfg_reg;      // clock source and prescaler
    logic [RESULT_W-1:0]   result_reg;      // last finished code
    logic                  conv_req_reg;    // conversion owed to software
    logic                  bus_req;         // new access this cycle
    logic                  scr_wr;          // control register write
    logic                  res_rd;          // result register read
    logic                  clk_wr;          // clock register write
    logic                  powered;         // channel field not all ones
    logic                  core_start;      // launch the converter
    logic                  core_abort;      // drop conversion in flight
    logic                  core_busy;       // converter running
    logic                  conv_done;       // one-cycle completion pulse
    logic                  adc_tick;        // converter clock enable
    logic [RESULT_W-1:0]   core_result;     // code from the converter
    logic [NUM_PINS-1:0]   owner;           // pin claimed by the converter
    logic [4:0]            ticks_seen;      // ticks since start, checks only

    // one-hot pin ownership; references and unused codes claim no pin
    function automatic logic [NUM_PINS-1:0] pin_owner(input logic [4:0] ch);
        pin_owner = '0;
        if (ch <= CH_LAST_PIN) begin
            pin_owner[ch[3:0]] = 1'b1;
        end
    endfunction

    // bus decode; a request counts only in its first cycle
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign scr_wr  = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == SCR_OFFSET);
    assign clk_wr  = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == CLKCFG_OFFSET);
    assign res_rd  = bus_req && !wb_we_i && (wb_adr_i == RESULT_OFFSET);

    assign powered = (ctrl_reg.channel != CH_OFF);

    assign core_abort = stop_mode || !powered;
    assign core_start = conv_req_reg && !core_busy && !core_abort;
    assign owner      = pin_owner(ctrl_reg.channel);

    // restart the divider with each conversion so every one gets full ticks
    adc_clk_div u_div (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .osc_tick (osc_tick),
        .cfg      (clkcfg_reg),
        .clear    (core_start),
        .adc_tick (adc_tick)
    );

    // unused channel codes simply convert whatever the comparator reports
    // unused codes convert unknown
    sar_core u_core (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .start    (core_start),
        .abort    (core_abort),
        .adc_tick (adc_tick),
        .cmp_in   (cmp_in),
        .dac_code (dac_code),
        .result   (core_result),
        .done     (conv_done),
        .busy     (core_busy)
    );

    // ack one cycle after the request, then drop for a cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // read data captured with the ack; unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                SCR_OFFSET:    wb_dat_o <= {24'h00_0000, ctrl_reg};
                RESULT_OFFSET: wb_dat_o <= {24'h00_0000, result_reg};
                CLKCFG_OFFSET: wb_dat_o <= {24'h00_0000, clkcfg_reg, 4'h0};
                default:       wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // control / status register
    // reset clears flag, enable, continuous
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrl_reg <= SCR_RESET;
        end else begin
            if (scr_wr) begin
                ctrl_reg.irq_en  <= wb_dat_i[IRQEN_BIT];
                ctrl_reg.cont    <= wb_dat_i[CONT_BIT];
                ctrl_reg.channel <= wb_dat_i[CH_MSB:0];
                ctrl_reg.done    <= wb_dat_i[IRQEN_BIT] && wb_dat_i[DONE_BIT];
            end else if (res_rd && !ctrl_reg.irq_en) begin
                ctrl_reg.done <= 1'b0;
            end
            // set wins over a clear in the same cycle
            // flag held while conversions continue
            if (conv_done && !ctrl_reg.irq_en) begin
                ctrl_reg.done <= 1'b1;
            end
        end
    end

    // clock configuration register
    // reset picks the oscillator
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            clkcfg_reg <= CLKCFG_RESET;
        end else if (clk_wr) begin
            clkcfg_reg.prescale <= wb_dat_i[DIV_MSB:DIV_LSB];
            clkcfg_reg.src_bus  <= wb_dat_i[SRC_BIT];
        end
    end

    // result register; overwritten whether or not it was read
    // update on every completion
    // result stored on the same clock edge that sets the flag
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            result_reg <= '0;
        end else if (conv_done) begin
            result_reg <= core_result;
        end
    end

    // pending conversion bookkeeping
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            conv_req_reg <= 1'b0;
        end else begin
            if (core_start) begin
                conv_req_reg <= 1'b0;
            end
            // continuous mode queues the next one
            if (conv_done && ctrl_reg.cont && powered) begin
                conv_req_reg <= 1'b1;
            end
            if (core_busy && stop_mode && powered) begin
                conv_req_reg <= 1'b1;
            end
            if (scr_wr) begin
                conv_req_reg <= (wb_dat_i[CH_MSB:0] != CH_OFF);
            end
            // power-off cancels anything owed
            if (!powered && !scr_wr) begin
                conv_req_reg <= 1'b0;
            end
        end
    end

    // interrupt request; set wins over a clear in the same cycle
    // raise on done, drop on control write or result read
    // wait mode does not gate it
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            done_irq <= 1'b0;
        end else begin
            if (scr_wr || res_rd) begin
                done_irq <= 1'b0;
            end
            if (conv_done && ctrl_reg.irq_en) begin
                done_irq <= 1'b1;
            end
        end
    end

    // analog mux select and power, registered for clean outputs
    // channel code drives the mux
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            selected_analog_input <= CH_OFF;
            analog_power_on       <= 1'b0;
        end else begin
            selected_analog_input <= ctrl_reg.channel;
            analog_power_on       <= powered;
        end
    end

    // port override; the converter pin never drives, whatever the port says
    // force selected pin to input
    // owned pin read returns 0 or latch
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            analog_channel_pin <= '0;
            pin_out            <= '0;
            pin_oe             <= '0;
            port_read_value    <= '0;
        end else begin
            analog_channel_pin <= owner;
            pin_out            <= port_data_latch;
            pin_oe             <= port_dir & ~owner;
            port_read_value    <= (owner & port_dir & port_data_latch)
                                | (~owner & ~port_dir & pin_in)
                                | (~owner & port_dir & port_data_latch);
        end
    end

    // converter ticks counted from start, read only by the checks
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ticks_seen <= 5'h00;
        end else if (core_start) begin
            ticks_seen <= 5'h00;
        end else if (core_busy && adc_tick) begin
            ticks_seen <= ticks_seen + 5'h01;
        end
    end

    a_conv_tick_count: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        conv_done |-> (ticks_seen == CONV_TICKS))
        else $error("conversion did not take sixteen converter ticks");

    a_result_follows_done: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        conv_done |=> (result_reg == $past(core_result)))
        else $error("result register missed a completion");

    a_flag_sets_done: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (conv_done && !ctrl_reg.irq_en) |=> ctrl_reg.done)
        else $error("completion flag not set after conversion");

    a_flag_read_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (res_rd && !ctrl_reg.irq_en && !conv_done) |=> !ctrl_reg.done)
        else $error("result read did not clear completion flag");

    a_irq_on_done: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (conv_done && ctrl_reg.irq_en) |=> done_irq)
        else $error("interrupt not raised at completion");

    a_irq_drop_access: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ((scr_wr || res_rd) && !(conv_done && ctrl_reg.irq_en)) |=> !done_irq)
        else $error("interrupt not dropped on register access");

    a_off_no_convert: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (ctrl_reg.channel == CH_OFF) |=> !core_busy)
        else $error("converter runs while powered off");

    a_stop_aborts: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        stop_mode |=> !core_busy)
        else $error("conversion continued in stop mode");

    a_cont_requeue: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (conv_done && ctrl_reg.cont && powered && !scr_wr) |=>
            conv_req_reg ##1 (core_busy || $past(core_abort)))
        else $error("continuous mode did not start the next conversion");

    a_pin_never_driven: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ##1 ((pin_oe & analog_channel_pin) == '0))
        else $error("converter pin driven by port logic");

endmodule

// ==== adc_seq_pkg.sv ====
package adc_seq_pkg;

    // register byte addresses on the wishbone slave
    localparam logic [7:0] SCR_OFFSET    = 8'h38;  // control / status
    localparam logic [7:0] RESULT_OFFSET = 8'h3c;  // conversion result
    localparam logic [7:0] CLKCFG_OFFSET = 8'h40;  // clock source and prescaler

    // field positions in the written data word
    localparam int DONE_BIT   = 7;  // completion flag
    localparam int IRQEN_BIT  = 6;  // interrupt enable
    localparam int CONT_BIT   = 5;  // continuous mode
    localparam int CH_MSB     = 4;  // channel field top bit
    localparam int DIV_MSB    = 7;  // prescaler field top bit
    localparam int DIV_LSB    = 5;  // prescaler field low bit
    localparam int SRC_BIT    = 4;  // clock source bit

    // channel codes
    localparam logic [4:0] CH_LAST_PIN = 5'h0e;  // highest pin channel
    localparam logic [4:0] CH_RESERVED = 5'h1b;  // reserved code
    localparam logic [4:0] CH_HIGH_REF = 5'h1d;  // high reference
    localparam logic [4:0] CH_LOW_REF  = 5'h1e;  // low reference
    localparam logic [4:0] CH_OFF      = 5'h1f;  // converter powered off
    localparam int         NUM_PINS    = 15;     // analog-capable port pins

    // reset values
    localparam logic [7:0] SCR_RESET    = 8'h1f;  // all channel bits set
    localparam logic [3:0] CLKCFG_RESET = 4'h0;   // oscillator, divide by 1

    // conversion timing in converter clock ticks
    localparam logic [4:0] CONV_TICKS = 5'h10;  // ticks per conversion
    localparam int         RESULT_W   = 8;      // result width

    // control / status register fields, bit 7 down to bit 0
    typedef struct packed {
        logic       done;     // completion flag
        logic       irq_en;   // interrupt enable
        logic       cont;     // continuous mode
        logic [4:0] channel;  // channel select
    } ctrl_s;

    // clock configuration fields
    typedef struct packed {
        logic [2:0] prescale;  // divide code
        logic       src_bus;   // 1: bus clock, 0: oscillator
    } clkcfg_s;

    typedef enum {CONV_IDLE, CONV_RUN} conv_state_e;

endpackage

// ==== adc_clk_div.sv ====
`timescale 1ns/1ps
module adc_clk_div import adc_seq_pkg::*; (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       osc_tick,   // one pulse per oscillator clock
    input  wire clkcfg_s    cfg,        // source and divide code
    input  wire logic       clear,      // restart the divider phase
    output logic            adc_tick    // one pulse per converter clock
);

    logic [3:0] cnt_reg;  // source ticks seen in this period

    // terminal count for each divide code; top bit set means divide by 16
    function automatic logic [3:0] div_term(input logic [2:0] code);
        unique case (code)
            3'h0:    div_term = 4'h0;
            3'h1:    div_term = 4'h1;
            3'h2:    div_term = 4'h3;
            3'h3:    div_term = 4'h7;
            default: div_term = 4'hf;
        endcase
    endfunction

    // divider; the bus clock source ticks every cycle
    // prescale ratio select
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_reg  <= 4'h0;
            adc_tick <= 1'b0;
        end else begin
            adc_tick <= 1'b0;
            if (clear) begin
                cnt_reg <= 4'h0;
            end else if (cfg.src_bus || osc_tick) begin
                if (cnt_reg >= div_term(cfg.prescale)) begin
                    cnt_reg  <= 4'h0;
                    adc_tick <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
        end
    end

endmodule

// ==== sar_core.sv ====
`timescale 1ns/1ps
module sar_core import adc_seq_pkg::*; (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                start,     // begin a conversion
    input  wire logic                abort,     // drop a conversion in progress
    input  wire logic                adc_tick,  // converter clock enable
    input  wire logic                cmp_in,    // 1: input at or above trial level
    output logic [RESULT_W-1:0]      dac_code,  // trial level to the comparator
    output logic [RESULT_W-1:0]      result,    // finished code
    output logic                     done,      // one-cycle completion pulse
    output logic                     busy       // conversion in progress
);

    conv_state_e         state_reg;  // idle or converting
    logic [4:0]          tick_reg;   // converter ticks into this conversion
    logic [RESULT_W-1:0] mask_reg;   // bit under trial, zero once resolved
    logic [RESULT_W-1:0] kept;       // trial with the current bit decided

    assign busy = (state_reg == CONV_RUN);

    // clear the trial bit when the comparator says the input is below it
    always_comb begin
        kept = cmp_in ? dac_code : (dac_code & ~mask_reg);
    end

    // successive approximation: 8 trial ticks, the rest settle
    // sixteen ticks per conversion
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg <= CONV_IDLE;
            tick_reg  <= 5'h00;
            mask_reg  <= '0;
            dac_code  <= '0;
            result    <= '0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_reg)
                CONV_IDLE: begin
                    if (start) begin
                        state_reg <= CONV_RUN;
                        tick_reg  <= 5'h00;
                        mask_reg  <= {1'b1, {(RESULT_W-1){1'b0}}};
                        dac_code  <= {1'b1, {(RESULT_W-1){1'b0}}};
                    end
                end
                CONV_RUN: begin
                    if (abort) begin
                        // stop or power-off loses the partial code
                        state_reg <= CONV_IDLE;
                    end else if (adc_tick) begin
                        tick_reg <= tick_reg + 5'h01;
                        if (mask_reg != '0) begin
                            mask_reg <= mask_reg >> 1;
                            dac_code <= kept | (mask_reg >> 1);
                        end
                        if (tick_reg == CONV_TICKS - 5'h01) begin
                            result    <= dac_code;
                            done      <= 1'b1;
                            state_reg <= CONV_IDLE;
                        end
                    end
                end
            endcase
        end
    end

endmodule

// ==== adc_front_model.sv ====
`timescale 1ns/1ps
module adc_front_model import adc_seq_pkg::*; (
    input  wire logic [RESULT_W-1:0] dac_code,               // trial level from the block
    input  wire logic [4:0]          selected_analog_input,  // mux code
    input  wire logic                analog_power_on,        // converter powered
    output logic                     cmp_in                  // comparator decision
);
    logic [7:0] level [0:31];  // input level per mux code, in result units
    logic       valid;         // mux code leads to a defined input

    // the bench sets pin levels through this
    task automatic set_level(input int code, input logic [7:0] v);
        level[code] = v;
    endtask

    // references sit at full scale and zero
    initial begin
        foreach (level[k]) level[k] = 8'h5a;
        level[CH_HIGH_REF] = 8'hff;
        level[CH_LOW_REF] = 8'h00;
    end

    // only pins and references give a real decision
    assign valid = selected_analog_input <= CH_LAST_PIN
                   || selected_analog_input == CH_HIGH_REF
                   || selected_analog_input == CH_LOW_REF;
    // unpowered or unused inputs flicker, so no stale answer helps
    assign cmp_in = (analog_power_on && valid) ? (level[selected_analog_input] >= dac_code)
                                               : ^dac_code;
endmodule

// ==== sar_adc_sequencer_bench.sv ====
`timescale 1ns/1ps
module sar_adc_sequencer_bench import adc_seq_pkg::*; ;
    logic        ref_clk = 0, rst_b = 0, osc_run = 0, osc_tick = 0, stop_mode = 0;
    logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, cmp_in;
    logic        analog_power_on, done_irq;
    logic [7:0]  wb_adr_i = 0, dac_code;
    logic [3:0]  wb_sel_i = 4'h1;  // only the low lane carries a register
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic [4:0]  selected_analog_input, ch;
    logic [14:0] pin_in = 0, port_data_latch = 0, port_dir = 0, m;
    logic [14:0] analog_channel_pin, pin_out, pin_oe, port_read_value;
    logic [31:0] exp_q [$];  // expected read data, oldest first
    int          num_errors = 0, n_checks = 0, seed = 32'h4f65, n, i;

    sar_adc_sequencer sar_adc_sequencer_i (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .osc_tick, .stop_mode, .cmp_in,
        .dac_code, .selected_analog_input, .analog_power_on, .done_irq, .pin_in,
        .port_data_latch, .port_dir, .analog_channel_pin, .pin_out, .pin_oe, .port_read_value);
    adc_front_model adc_front_model_i (.dac_code, .selected_analog_input, .analog_power_on,
        .cmp_in);

    always #4 ref_clk = ~ref_clk;
    // oscillator ticks arrive at random while allowed to run
    always @(posedge ref_clk) osc_tick <= osc_run & 1'($random(seed));

    // tally one comparison, report at once on a difference
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    // one classic cycle; a read notes d as its expected data
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
        if (!w) exp_q.push_back({24'h0, d});
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50) check("bus ack", 1, 0);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge ref_clk);
    endtask
    // bounded wait for the request line
    task automatic wait_irq(input int lim);
        n = 0;
        while (done_irq !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    // interrupt-mode conversion, its length judged against dv clocks per tick
    task automatic conv(input logic [4:0] c, input int dv);
        bus(1, SCR_OFFSET, {3'b010, c});
        wait_irq(20 * dv + 10);
        check("conv cycles", 1, 32'(n >= 16 * dv - 2 && n <= 17 * dv + 2));
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // read data is matched here, in issue order
    always @(posedge ref_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
            check("read data", exp_q.pop_front(), wb_dat_o);
    end

    initial begin
        #100000;
        num_errors++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        for (i = 0; i < 15; i++) adc_front_model_i.set_level(i, 8'($random(seed)));
        rst_b <= 1;
        @(posedge ref_clk);
        bus(0, SCR_OFFSET, 8'h1f);
        bus(0, CLKCFG_OFFSET, 8'h00);
        bus(0, 8'h44, 8'h00);
        check("power", 0, analog_power_on);
        bus(1, CLKCFG_OFFSET, 8'h10);
        conv(5'h00, 1);
        // every pin code, both references and one unused code
        for (i = 0; i < 18; i++) begin
            ch = (i < 15) ? 5'(i) : (i == 17) ? 5'h14 : 5'(i + 14);
            m = (i < 15) ? 15'(1 << i) : 15'h0;
            {pin_in, port_data_latch, port_dir} <= 45'({$random(seed), $random(seed)});
            conv(ch, 1);
            check("mux", ch, selected_analog_input);
            check("power on", 1, analog_power_on);
            check("claim", m, analog_channel_pin);
            check("oe", port_dir & ~m, pin_oe);
            check("pin out", port_data_latch, pin_out);
            check("port read", (port_dir & port_data_latch) | (~port_dir & ~m & pin_in),
                  port_read_value);
            bus(0, SCR_OFFSET, {3'b010, ch});
            if (i < 17) begin
                bus(0, RESULT_OFFSET, adc_front_model_i.level[ch]);
                check("irq drop", 0, done_irq);
            end
        end
        bus(1, SCR_OFFSET, 8'hc1);
        bus(0, SCR_OFFSET, 8'hc1);
        bus(1, SCR_OFFSET, 8'h82);
        bus(0, SCR_OFFSET, 8'h02);
        repeat (24) @(posedge ref_clk);
        check("irq idle", 0, done_irq);
        bus(0, SCR_OFFSET, 8'h82);
        bus(0, RESULT_OFFSET, adc_front_model_i.level[2]);
        repeat (40) @(posedge ref_clk);
        bus(0, SCR_OFFSET, 8'h02);
        bus(1, SCR_OFFSET, 8'h25);
        repeat (40) @(posedge ref_clk);
        adc_front_model_i.set_level(5, 8'hc3);
        repeat (40) @(posedge ref_clk);
        bus(0, SCR_OFFSET, 8'ha5);
        bus(0, RESULT_OFFSET, 8'hc3);
        bus(1, SCR_OFFSET, 8'h1f);
        repeat (40) @(posedge ref_clk);
        bus(0, SCR_OFFSET, 8'h1f);
        check("power off", 0, analog_power_on);
        bus(1, SCR_OFFSET, 8'h43);
        repeat (8) @(posedge ref_clk);
        stop_mode <= 1;
        wait_irq(60);
        check("stopped", 0, done_irq);
        stop_mode <= 0;
        wait_irq(60);
        check("resumed", 1, done_irq);
        // divide codes 0..3 and one with the top bit set
        for (i = 0; i < 5; i++) begin
            bus(1, CLKCFG_OFFSET, {(i == 4) ? 3'h7 : 3'(i), 5'h10});
            conv(5'h00, 1 << i);
        end
        bus(1, CLKCFG_OFFSET, 8'h00);
        bus(1, SCR_OFFSET, 8'h40);
        wait_irq(60);
        check("osc held", 0, done_irq);
        osc_run <= 1;
        wait_irq(400);
        check("osc runs", 1, done_irq);
        close_out();
    end
endmodule
